/* hdl/fhs_top.sv */
// Feeder host status interface: start edge, status outputs, loader link.
// All logic runs on the one system clock; the filter and select spans
// are counts of that clock, set by the parameters below.
// Assumes start and loader status are already level-shifted to logic.
`timescale 1ns/1ps
module fhs_top import fhs_pkg::*; #(
   parameter int unsigned FILT_N = FILT_CYCLES,
   parameter int unsigned INIT_N = INIT_CYCLES,
   parameter int unsigned SEL_N = SEL_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // APB slave, one wait-free access cycle
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Host, machine and loader side inputs
   input wire logic feed_start_pulse_in_i,
   input wire logic loader_status_in_i,
   input wire logic low_product_i,
   input wire logic fault_i,
   input wire logic feed_done_i,
   input wire logic misfeed_event_i,
   input wire logic jam_event_i,
   // Status outputs, all straight from flops
   output logic feed_go_o,
   output logic low_product_out_o,
   output logic auto_on_out_o,
   output logic cycle_complete_out_o,
   output logic fault_lamp_out_o,
   output logic ready_out_o,
   output logic loader_enable_out_o,
   output logic loader_status_select_o,
   output logic configurable_aux_out_o
);
   // ==========================================================
   // State
   typedef struct packed {
      // Main sequence and control
      fhs_state_t st;
      logic [CNT_W-1:0] init_cnt;
      logic [CTRL_W-1:0] ctrl;
      // Input conditioning
      logic [1:0] start_sync;
      logic [CNT_W-1:0] start_cnt;
      logic start_filt;
      logic start_prev;
      logic [1:0] ldr_sync;
      logic [CNT_W-1:0] ldr_cnt;
      logic ldr_filt;
      // Loader status sampling and ready flag
      logic [CNT_W-1:0] sel_cnt;
      logic sel;
      logic ldr_present;
      logic ldr_ready;
      logic rdy_flag;
      // Bus answer
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      // Output flops
      logic feed_go;
      logic low_product_out;
      logic auto_out;
      logic cyc_cmp;
      logic lamp;
      logic ready;
      logic ldr_en;
      logic aux;
   } fhs_regs_t;

   fhs_regs_t s_q;
   fhs_regs_t s_d;

   // A span of n cycles is over once the counter reaches n - 1
   function automatic logic cnt_end(input logic [CNT_W-1:0] cnt, input int unsigned n);
      return cnt >= CNT_W'(n - 1);
   endfunction

   // Plain counter step, same width as the counter
   function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] cnt);
      return cnt + CNT_W'(1);
   endfunction

   // Feeding decode, shared by busy status, cycle complete and aux
   function automatic logic is_feed(input fhs_state_t st);
      return st == FHS_FEED;
   endfunction

   // Initialisation decode; everything shows red until it is over
   function automatic logic is_init(input fhs_state_t st);
      return st == FHS_INIT;
   endfunction

   // Debounce: follow raw only after it stayed different for n cycles
   function automatic logic [CNT_W:0] filt_step(input logic raw, input logic cur,
                                                input logic [CNT_W-1:0] cnt,
                                                input int unsigned n);
      logic [CNT_W:0] r;
      r = {cur, cnt};
      if (raw == cur) begin
         r = {cur, {CNT_W{1'b0}}};
      end else if (cnt_end(cnt, n)) begin
         r = {raw, {CNT_W{1'b0}}};
      end else begin
         r = {cur, cnt_inc(cnt)};
      end
      return r;
   endfunction

   // Decodes shared inside the next-state process
   logic setup_w;
   logic wr_w;
   logic green_w;
   logic start_edge_w;
   logic [ST_W-1:0] stat_w;

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      setup_w = psel_i & ~penable_i;
      wr_w = psel_i & penable_i & pwrite_i & s_q.pready;
      s_d.feed_go = 1'b0;

      // Two-flop synchronisers, then filters on the second stage
      // A level held for less than the filter span is never seen
      s_d.start_sync = {s_q.start_sync[0], feed_start_pulse_in_i};
      s_d.ldr_sync = {s_q.ldr_sync[0], loader_status_in_i};
      {s_d.start_filt, s_d.start_cnt} = filt_step(s_q.start_sync[1], s_q.start_filt,
                                                  s_q.start_cnt, FILT_N);
      {s_d.ldr_filt, s_d.ldr_cnt} = filt_step(s_q.ldr_sync[1], s_q.ldr_filt,
                                              s_q.ldr_cnt, FILT_N);
      s_d.start_prev = s_q.start_filt;
      start_edge_w = s_q.start_filt & ~s_q.start_prev;

      // Select phases: low reads presence, high reads readiness
      // Status is taken only at the end of a phase, so the filter span
      // must be shorter than a phase or the old phase is read again
      if (cnt_end(s_q.sel_cnt, SEL_N)) begin
         s_d.sel_cnt = '0;
         s_d.sel = ~s_q.sel;
         if (s_q.sel) begin
            s_d.ldr_ready = s_q.ldr_filt;
         end else begin
            s_d.ldr_present = s_q.ldr_filt;
         end
      end else begin
         s_d.sel_cnt = cnt_inc(s_q.sel_cnt);
      end

      // Main sequence
      case (s_q.st)
         FHS_INIT: begin
            // Red hold while the machine side settles after reset
            if (cnt_end(s_q.init_cnt, INIT_N)) begin
               s_d.st = FHS_IDLE;
            end else begin
               s_d.init_cnt = cnt_inc(s_q.init_cnt);
            end
         end
         FHS_IDLE: begin
            // Starts while off or faulted are dropped, not queued
            if (start_edge_w && s_q.ctrl[CTRL_AUTO_ON] && !fault_i) begin
               s_d.st = FHS_FEED;
               s_d.feed_go = 1'b1;
               s_d.rdy_flag = 1'b1;
            end
         end
         FHS_FEED: begin
            // A fault ends the cycle at once; the host waits for the clear
            if (feed_done_i || fault_i) begin
               s_d.st = FHS_IDLE;
            end
         end
         default: begin
            s_d.st = FHS_INIT;
         end
      endcase

      // An event in the start cycle still wins over the re-arm,
      // so a misfeed seen at the start edge leaves ready low
      if ((misfeed_event_i && s_q.ctrl[CTRL_MISFEED_RDY]) ||
          (jam_event_i && s_q.ctrl[CTRL_JAM_RDY])) begin
         s_d.rdy_flag = 1'b0;
      end

      // Status outputs, red while initialising. Green takes the ready flag
      // as it leaves this cycle, so a ready flag change moves ready, lamp and
      // loader enable on the same edge; a fault alone moves lamp, loader enable and cycle complete.
      green_w = !is_init(s_q.st) && !fault_i && s_d.rdy_flag;
      if (is_init(s_q.st)) begin
         // Cycle complete is forced high here whatever the polarity option
         s_d.low_product_out = 1'b0;
         s_d.auto_out = 1'b0;
         s_d.cyc_cmp = 1'b1;
         s_d.lamp = 1'b1;
         s_d.ready = 1'b0;
         s_d.ldr_en = 1'b0;
         s_d.aux = 1'b0;
      end else begin
         s_d.low_product_out = low_product_i;
         s_d.auto_out = s_q.ctrl[CTRL_AUTO_ON];
         // Busy comes from the next state, so the host sees cycle
         // complete show busy in the same cycle as the start pulse
         s_d.cyc_cmp = (is_feed(s_d.st) | fault_i | ~green_w
                        | ~s_q.ctrl[CTRL_AUTO_ON])
                       ^ s_q.ctrl[CTRL_CYC_INV];
         // Red covers both a fault and a cleared ready flag
         s_d.lamp = ~green_w;
         s_d.ready = s_d.rdy_flag;
         s_d.ldr_en = green_w;
         // General output; the software source lets the host drive it freely
         case (s_q.ctrl[CTRL_AUX_LO +: 2])
            AUX_READY: s_d.aux = s_d.rdy_flag;
            AUX_BUSY: s_d.aux = is_feed(s_d.st);
            AUX_LDR_RDY: s_d.aux = s_q.ldr_present & s_q.ldr_ready;
            AUX_SW: s_d.aux = s_q.ctrl[CTRL_AUX_SW];
            default: s_d.aux = 1'b0;
         endcase
      end

      // APB: answer prepared in setup, one access cycle
      // Unmapped offsets answer with an error and read as zero
      stat_w = '0;
      stat_w[ST_INIT_DONE] = !is_init(s_q.st);
      stat_w[ST_BUSY] = is_feed(s_q.st);
      stat_w[ST_READY] = s_q.rdy_flag;
      stat_w[ST_LDR_PRESENT] = s_q.ldr_present;
      stat_w[ST_LDR_READY] = s_q.ldr_ready;
      stat_w[ST_START_LVL] = s_q.start_filt;
      s_d.pready = setup_w;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      if (setup_w) begin
         if (paddr_i == CTRL_OFS) begin
            s_d.prdata = {{(32 - CTRL_W){1'b0}}, s_q.ctrl};
         end else if (paddr_i == STAT_OFS) begin
            s_d.prdata = {{(32 - ST_W){1'b0}}, stat_w};
            s_d.pslverr = pwrite_i; // Status is read-only
         end else begin
            s_d.pslverr = 1'b1;
         end
      end
      // Writes land at the access edge, when pready already stands high
      if (wr_w && paddr_i == CTRL_OFS) begin
         s_d.ctrl = pwdata_i[CTRL_W-1:0];
      end
   end

   // ==========================================================
   // Registers
   // Reset leaves the block red with the ready flag armed, so no start
   // is needed to turn the lamp green once initialisation is over
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '0;
         s_q.st <= FHS_INIT;
         s_q.ctrl <= CTRL_RST[CTRL_W-1:0];
         s_q.rdy_flag <= 1'b1;
         s_q.cyc_cmp <= 1'b1;
         s_q.lamp <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs straight from flops
   // Each pin is one field of the state, so no logic sits behind a pin
   assign prdata_o = s_q.prdata;
   assign pready_o = s_q.pready;
   assign pslverr_o = s_q.pslverr;
   assign feed_go_o = s_q.feed_go;
   assign low_product_out_o = s_q.low_product_out;
   assign auto_on_out_o = s_q.auto_out;
   assign cycle_complete_out_o = s_q.cyc_cmp;
   assign fault_lamp_out_o = s_q.lamp;
   assign ready_out_o = s_q.ready;
   assign loader_enable_out_o = s_q.ldr_en;
   assign loader_status_select_o = s_q.sel;
   assign configurable_aux_out_o = s_q.aux;
endmodule

/* common/fhs_pkg.sv */
// Constants, register map and types for the feeder host status block.
// Assumes a 50 MHz system clock and an APB slave with 32-bit data.
package fhs_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned FILT_TIME_NS = 100000;
   localparam int unsigned INIT_TIME_NS = 1000000;
   localparam int unsigned SEL_TIME_NS = 2000000;
   localparam int unsigned FILT_CYCLES = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SEL_CYCLES = SEL_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 17;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // Control fields
   localparam int unsigned CTRL_AUTO_ON = 0;
   localparam int unsigned CTRL_CYC_INV = 1;
   localparam int unsigned CTRL_MISFEED_RDY = 2;
   localparam int unsigned CTRL_JAM_RDY = 3;
   localparam int unsigned CTRL_AUX_LO = 4;
   localparam int unsigned CTRL_AUX_SW = 6;
   localparam int unsigned CTRL_W = 7;

   // Status fields
   localparam int unsigned ST_INIT_DONE = 0;
   localparam int unsigned ST_BUSY = 1;
   localparam int unsigned ST_READY = 2;
   localparam int unsigned ST_LDR_PRESENT = 3;
   localparam int unsigned ST_LDR_READY = 4;
   localparam int unsigned ST_START_LVL = 5;
   localparam int unsigned ST_W = 6;

   // Aux output sources
   localparam logic [1:0] AUX_READY = 2'h0;
   localparam logic [1:0] AUX_BUSY = 2'h1;
   localparam logic [1:0] AUX_LDR_RDY = 2'h2;
   localparam logic [1:0] AUX_SW = 2'h3;

   typedef enum logic [1:0] {
      FHS_INIT,
      FHS_IDLE,
      FHS_FEED
   } fhs_state_t;
endpackage

/* verif/fhs_top_sva.sv */
// Port checker for the feeder host status block.
// Assumes a bind from the bench, ports connected by name.
`timescale 1ns/1ps
module fhs_top_sva (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic low_product_i,
   input wire logic fault_i,
   input wire logic feed_go_o,
   input wire logic low_product_out_o,
   input wire logic auto_on_out_o,
   input wire logic cycle_complete_out_o,
   input wire logic fault_lamp_out_o,
   input wire logic ready_out_o,
   input wire logic loader_enable_out_o,
   input wire logic loader_status_select_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // ======
   // Red outputs, and a start taken while green
   sequence s_red;
      cycle_complete_out_o && fault_lamp_out_o && !ready_out_o && !loader_enable_out_o;
   endsequence
   sequence s_go;
      feed_go_o && !fault_lamp_out_o;
   endsequence
   init_red_a: assert property ($rose(nrst_i) |-> s_red [*8])
      else $error("red not held after reset");
   go_once_a: assert property (feed_go_o |=> !feed_go_o [*2])
      else $error("start pulse repeated");
   go_auto_a: assert property (feed_go_o |-> auto_on_out_o)
      else $error("start taken with auto off");
   go_cc_a: assert property (s_go ##0 $past(!fault_lamp_out_o && auto_on_out_o) |->
      $changed(cycle_complete_out_o))
      else $error("cycle complete missed busy");
   low_product_out_a: assert property (low_product_out_o |-> $past(low_product_i))
      else $error("low product without cause");
   fault_red_a: assert property (fault_i |=> fault_lamp_out_o && !loader_enable_out_o)
      else $error("fault not shown red");
   lamp_ldr_a: assert property (fault_lamp_out_o != loader_enable_out_o)
      else $error("loader enable disagrees with lamp");
   rdy_lamp_a: assert property (!ready_out_o |-> fault_lamp_out_o)
      else $error("not ready but green");
   sel_hold_a: assert property ($changed(loader_status_select_o) |=>
      $stable(loader_status_select_o) [*8])
      else $error("select toggled too soon");
   apb_rdy_a: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("bad ready timing");
endmodule

/* verif/fhs_loader_model.sv */
// Product loader model answering the status select line.
// Assumes select is a level driven by the block on the system clock.
`timescale 1ns/1ps
module fhs_loader_model (
   input wire logic ref_clk_i,
   input wire logic sel_i,
   input wire logic present_i,
   input wire logic ready_i,
   output logic status_o
);
   // ======
   // Low phase reports presence, high phase presence and readiness together; select only read
   always @(posedge ref_clk_i) begin
      status_o <= sel_i ? (present_i & ready_i) : present_i;
   end
endmodule

/* verif/fhs_top_tb.sv */
// Bench for the feeder host status block: APB, start, loader, status.
// Assumes the checker and loader model are compiled before it.
`timescale 1ns/1ps
module fhs_top_tb;
   import fhs_pkg::*;
   localparam int F = 4, I = 16, S = 32;
   logic ref_clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic feed_start_pulse_in_i = 0, low_product_i = 0, fault_i = 0, feed_done_i = 0;
   logic misfeed_event_i = 0, jam_event_i = 0, pres = 0, lrdy = 0;
   logic [11:0] paddr_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o, rd;
   logic pready_o, pslverr_o, loader_status_in_i, feed_go_o, low_product_out_o;
   logic auto_on_out_o, cycle_complete_out_o, fault_lamp_out_o, ready_out_o;
   logic loader_enable_out_o, loader_status_select_o, configurable_aux_out_o;
   int mismatches = 0, n_tests = 0, gos = 0;
   fhs_top #(.FILT_N(F), .INIT_N(I), .SEL_N(S)) DUT (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o),
      .feed_start_pulse_in_i(feed_start_pulse_in_i),
      .loader_status_in_i(loader_status_in_i), .low_product_i(low_product_i),
      .fault_i(fault_i), .feed_done_i(feed_done_i), .misfeed_event_i(misfeed_event_i),
      .jam_event_i(jam_event_i), .feed_go_o(feed_go_o),
      .low_product_out_o(low_product_out_o), .auto_on_out_o(auto_on_out_o),
      .cycle_complete_out_o(cycle_complete_out_o), .fault_lamp_out_o(fault_lamp_out_o),
      .ready_out_o(ready_out_o), .loader_enable_out_o(loader_enable_out_o),
      .loader_status_select_o(loader_status_select_o),
      .configurable_aux_out_o(configurable_aux_out_o));
   fhs_loader_model u_ldr (.ref_clk_i(ref_clk_i), .sel_i(loader_status_select_o),
      .present_i(pres), .ready_i(lrdy), .status_o(loader_status_in_i));
   // ======
   // Clock, start counter, watchdog
   initial forever #10 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) if (feed_go_o === 1'b1) gos <= gos + 1;
   initial begin
      #400000;
      mismatches++;
      print_verdict();
   end
   // ======
   // Checking helpers
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s exp %h got %h", nm, exp, got);
      end
   endtask
   function automatic logic [3:0] exp_st(bit au, bit inv, bit grn, bit busy);
      return {au, (busy | !grn | !au) ^ inv, !grn, grn};
   endfunction
   task automatic st(bit au, bit inv, bit grn, bit busy);
      repeat (3) @(posedge ref_clk_i);
      chk("st", {auto_on_out_o, cycle_complete_out_o, fault_lamp_out_o, loader_enable_out_o},
         exp_st(au, inv, grn, busy));
   endtask
   // ======
   // Drivers: APB transfer, host start pulse, one full feed
   task automatic apb(bit wr, logic [11:0] a, logic [31:0] d, bit err);
      @(posedge ref_clk_i);
      psel_i <= 1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1;
      // No local limit: only the watchdog ends a wait that never answers
      do begin
         @(posedge ref_clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      chk("slverr", pslverr_o, err);
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task automatic pulse();
      @(posedge ref_clk_i) feed_start_pulse_in_i <= 1;
      repeat (30) @(posedge ref_clk_i);
      feed_start_pulse_in_i <= 0;
   endtask
   task automatic feed();
      pulse();
      st(1, 0, 1, 1);
      chk("aux", configurable_aux_out_o, 1);
      @(posedge ref_clk_i) feed_done_i <= 1;
      @(posedge ref_clk_i) feed_done_i <= 0;
      // Host does not index until cycle complete is low again
      do begin
         @(posedge ref_clk_i);
      end while (cycle_complete_out_o !== 1'b0);
      st(1, 0, 1, 0);
   endtask
   // ======
   // Main sequence
   initial begin
      void'($urandom(32'h87cd));
      repeat (10) @(posedge ref_clk_i);
      nrst_i <= 1;
      repeat (I + 4) @(posedge ref_clk_i);
      apb(0, CTRL_OFS, 0, 0);
      chk("ctrl", rd, CTRL_RST);
      apb(0, 12'h008, 0, 1);
      apb(1, STAT_OFS, 0, 1);
      for (int c = 0; c < 4; c++) begin
         apb(1, CTRL_OFS, 32'hffff_ff80 | c, 0);
         apb(0, CTRL_OFS, 0, 0);
         chk("ctrl", rd, c);
         st(c[0], c[1], 1, 0);
      end
      apb(1, CTRL_OFS, 32'h11, 0);
      feed();
      chk("gos", gos, 1);
      for (int e = 0; e < 2; e++) begin
         apb(1, CTRL_OFS, 32'h1 | (32'h4 << e), 0);
         @(posedge ref_clk_i) {jam_event_i, misfeed_event_i} <= 2'h1 << e;
         @(posedge ref_clk_i) {jam_event_i, misfeed_event_i} <= 2'h0;
         st(1, 0, 0, 0);
         chk("rdy", ready_out_o, 0);
         feed();
         chk("rdy", ready_out_o, 1);
      end
      @(posedge ref_clk_i) fault_i <= 1;
      st(1, 0, 0, 0);
      pulse();
      @(posedge ref_clk_i) fault_i <= 0;
      st(1, 0, 1, 0);
      chk("gos", gos, 3);
      repeat (20) begin
         @(posedge ref_clk_i) low_product_i <= 1'($urandom);
         repeat (2) @(posedge ref_clk_i);
         chk("lowp", low_product_out_o, low_product_i);
      end
      apb(1, CTRL_OFS, 32'h21, 0);
      repeat (4) begin
         @(posedge ref_clk_i) {pres, lrdy} <= 2'($urandom);
         repeat (2 * S + 3 * F + 8) @(posedge ref_clk_i);
         apb(0, STAT_OFS, 0, 0);
         chk("ldr", rd[4:3], {pres & lrdy, pres});
         chk("aux", configurable_aux_out_o, pres & lrdy);
      end
      for (int w = 0; w < 2; w++) begin
         apb(1, CTRL_OFS, 32'h31 | (w << 6), 0);
         repeat (3) @(posedge ref_clk_i);
         chk("sw", configurable_aux_out_o, w[0]);
      end
      print_verdict();
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
endmodule
bind fhs_top fhs_top_sva u_sva (
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .low_product_i(low_product_i), .fault_i(fault_i),
   .feed_go_o(feed_go_o), .low_product_out_o(low_product_out_o),
   .auto_on_out_o(auto_on_out_o), .cycle_complete_out_o(cycle_complete_out_o),
   .fault_lamp_out_o(fault_lamp_out_o), .ready_out_o(ready_out_o),
   .loader_enable_out_o(loader_enable_out_o),
   .loader_status_select_o(loader_status_select_o));
